// file: rtl/ldac_pkg.sv
`default_nettype none
package ldac_pkg;
    // ------------------------------------------------------------
    // Field layout of the two control words
    // ------------------------------------------------------------
    localparam int          LDAC_CODE_W       = 5;      // Level code width
    localparam int          LDAC_LEVELS       = 32;     // Selectable taps
    localparam int          LDAC_CTL0_EN_BIT  = 7;      // Ladder enable
    localparam int          LDAC_CTL0_OE_BIT  = 5;      // Pin drive enable
    localparam int          LDAC_CTL0_PSS_LSB = 2;      // Positive select low bit
    localparam int          LDAC_CTL0_NSS_BIT = 0;      // Negative select
    localparam logic [7:0]  LDAC_CTL0_WMASK   = 8'had;  // Writable bits of control 0
    localparam logic [7:0]  LDAC_CTL1_WMASK   = 8'h1f;  // Writable bits of control 1
    localparam logic [7:0]  LDAC_CTL0_RST     = 8'h00;  // Reset value of control 0
    localparam logic [7:0]  LDAC_CTL1_RST     = 8'h00;  // Reset value of control 1

    // ------------------------------------------------------------
    // Source selections
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LDAC_PSS_SUPPLY = 2'h0,     // Supply rail
        LDAC_PSS_EXTREF = 2'h1,     // External positive reference pin
        LDAC_PSS_FIXED  = 2'h2,     // Fixed reference
        LDAC_PSS_RSVD   = 2'h3      // Reserved
    } ldac_pss_t;

    typedef enum logic {
        LDAC_NSS_GROUND = 1'b0,     // Ground
        LDAC_NSS_EXTREF = 1'b1      // External negative reference pin
    } ldac_nss_t;

    // Enable and pin-drive state machine, Gray coded along the usual path
    typedef enum logic [1:0] {
        LDAC_ST_OFF   = 2'h0,       // Ladder off
        LDAC_ST_ON    = 2'h1,       // Ladder on, internal only
        LDAC_ST_DRIVE = 2'h3,       // Ladder on and driving the pin
        LDAC_ST_PARK  = 2'h2        // Pin connected, ladder off
    } ldac_state_t;
endpackage : ldac_pkg
`default_nettype wire

// file: rtl/ldac_tap_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// One-hot tap select from the level code
// ----------------------------------------------------------------
module ldac_tap_decode (
    input  wire logic                                    enable,
    input  wire logic [ldac_pkg::LDAC_CODE_W-1:0]        code,
    output logic      [ldac_pkg::LDAC_LEVELS-1:0]        tap_sel
);
    // Tap k connects ladder node k: neg ref + span * k / 32; tap 0 is neg ref
    always_comb begin
        tap_sel = '0;
        if (enable) begin
            tap_sel[code] = 1'b1;
        end
    end
endmodule : ldac_tap_decode
`default_nettype wire

// file: rtl/ldac_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ldac_ctrl (
    input  wire logic        clk_sys,        // System clock
    input  wire logic        rst,            // Device reset, sync
    input  wire logic        ce,             // Clock enable
    input  wire logic        sleep_mode,     // Device is in sleep
    input  wire logic        wake_event,     // Wake by interrupt or watchdog
    input  wire logic        ctl0_wr,        // Write strobe, control 0
    input  wire logic        ctl1_wr,        // Write strobe, control 1
    input  wire logic [7:0]  wr_data,        // Write data
    output logic      [7:0]  ctl0_rd,        // Control 0 readback
    output logic      [7:0]  ctl1_rd,        // Control 1 readback
    input  wire logic        pin_in_raw,     // Pin level, asynchronous
    input  wire logic        pin_dig_out,    // Port digital output
    input  wire logic        pin_dig_oe,     // Port output enable
    input  wire logic        pin_pullup_req, // Port weak pull-up request
    input  wire logic        pin_ccd_req,    // Port constant-current request
    output logic             pin_out,        // Digital pin output
    output logic             pin_oe,         // Digital buffer enable
    output logic             pin_in_en,      // Input detector enable
    output logic             pin_pullup_en,  // Weak pull-up enable
    output logic             pin_ccd_en,     // Constant-current enable
    output logic             pin_rd,         // Digital pin read value
    output logic             ladder_enable,  // Ladder powered
    output logic             pin_drive_enable, // Analog switch to pin
    output logic      [1:0]  positive_source_select, // Top of ladder
    output logic             negative_source_select, // Bottom of ladder
    output logic      [4:0]  level_code,     // Registered code
    output logic      [31:0] tap_sel         // One-hot tap switch
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                   en;      // Ladder enable
        logic                   oe;      // Pin drive enable
        ldac_pkg::ldac_pss_t    pss;     // Positive source
        ldac_pkg::ldac_nss_t    nss;     // Negative source
        logic [4:0]             code;    // Level code
        ldac_pkg::ldac_state_t  st;      // Mode state
        logic                   sy1;     // Pin sync stage 1
        logic                   sy2;     // Pin sync stage 2
        logic [7:0]             out_rd0; // Readback 0
        logic [7:0]             out_rd1; // Readback 1
        logic                   drv;     // Registered pin drive
    } ldac_reg_t;

    ldac_reg_t state_ff;        // Registered state
    ldac_reg_t nxt_state;       // Next state

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Pack control 0 from its fields; unimplemented bits read zero
    function automatic logic [7:0] ldac_pack0(input logic en, input logic oe,
                                              input logic [1:0] pss, input logic nss);
        logic [7:0] v;
        v = 8'h00;
        v[ldac_pkg::LDAC_CTL0_EN_BIT] = en;
        v[ldac_pkg::LDAC_CTL0_OE_BIT] = oe;
        v[ldac_pkg::LDAC_CTL0_PSS_LSB +: 2] = pss;
        v[ldac_pkg::LDAC_CTL0_NSS_BIT] = nss;
        return v & ldac_pkg::LDAC_CTL0_WMASK;
    endfunction : ldac_pack0

    // Mode derived from the two enables
    function automatic ldac_pkg::ldac_state_t ldac_mode(input logic en, input logic oe);
        case ({en, oe})
            2'b10:   return ldac_pkg::LDAC_ST_ON;
            2'b11:   return ldac_pkg::LDAC_ST_DRIVE;
            2'b01:   return ldac_pkg::LDAC_ST_PARK;
            default: return ldac_pkg::LDAC_ST_OFF;
        endcase
    endfunction : ldac_mode

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Sleep and wake are deliberately not inputs to any update term:
    // the control words only change on writes or reset.
    always_comb begin
        nxt_state     = state_ff;
        nxt_state.sy1 = pin_in_raw;         // Pin first stage
        nxt_state.sy2 = state_ff.sy1;       // Pin second stage
        if (ctl0_wr) begin
            nxt_state.en  = wr_data[ldac_pkg::LDAC_CTL0_EN_BIT];
            nxt_state.oe  = wr_data[ldac_pkg::LDAC_CTL0_OE_BIT];
            // Reserved positive select is stored as written
            nxt_state.pss = ldac_pkg::ldac_pss_t'(
                wr_data[ldac_pkg::LDAC_CTL0_PSS_LSB +: 2]);
            nxt_state.nss = ldac_pkg::ldac_nss_t'(
                wr_data[ldac_pkg::LDAC_CTL0_NSS_BIT]);
        end
        if (ctl1_wr) begin
            nxt_state.code = wr_data[ldac_pkg::LDAC_CODE_W-1:0];
        end
        // Mode tracks enables
        case (state_ff.st)
            ldac_pkg::LDAC_ST_OFF,
            ldac_pkg::LDAC_ST_ON,
            ldac_pkg::LDAC_ST_DRIVE,
            ldac_pkg::LDAC_ST_PARK: begin
                nxt_state.st = ldac_mode(nxt_state.en, nxt_state.oe);
            end
            default: begin
                nxt_state.st = ldac_pkg::LDAC_ST_OFF;
            end
        endcase
        nxt_state.drv     = nxt_state.oe;
        nxt_state.out_rd0 = ldac_pack0(nxt_state.en, nxt_state.oe,
                                       nxt_state.pss, nxt_state.nss);
        nxt_state.out_rd1 = {3'h0, nxt_state.code} & ldac_pkg::LDAC_CTL1_WMASK;
    end

    // ------------------------------------------------------------
    // Register
    // ------------------------------------------------------------
    // Reset returns every control field to zero; sleep never does
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= '0;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ctl0_rd                = state_ff.out_rd0;
    assign ctl1_rd                = state_ff.out_rd1;
    assign ladder_enable          = state_ff.en;
    assign pin_drive_enable       = state_ff.drv;
    assign positive_source_select = state_ff.pss;
    assign negative_source_select = state_ff.nss;
    assign level_code             = state_ff.code;

    // Digital functions of the pin are overridden while it carries the level
    assign pin_out       = state_ff.drv ? 1'b0 : pin_dig_out;
    assign pin_oe        = state_ff.drv ? 1'b0 : pin_dig_oe;
    assign pin_in_en     = ~state_ff.drv;
    assign pin_pullup_en = state_ff.drv ? 1'b0 : pin_pullup_req;
    assign pin_ccd_en    = state_ff.drv ? 1'b0 : pin_ccd_req;
    // Only the second sync stage feeds the read path
    assign pin_rd        = state_ff.drv ? 1'b0 : state_ff.sy2;

    // Ladder powered in the two modes that have the enable set
    logic taps_live;                // Tap switches may close
    assign taps_live = (state_ff.st == ldac_pkg::LDAC_ST_ON) ||
                       (state_ff.st == ldac_pkg::LDAC_ST_DRIVE);

    // Tap switches; ladder off opens every switch
    ldac_tap_decode i_ldac_tap_decode (
        .enable  (taps_live),
        .code    (state_ff.code),
        .tap_sel (tap_sel)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_en_follows: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && ctl0_wr) |=> (ladder_enable == $past(wr_data[ldac_pkg::LDAC_CTL0_EN_BIT])))
        else $error("ladder enable did not follow write");
    a_tap_onehot: assert property (@(posedge clk_sys) disable iff (rst)
        ladder_enable |-> $onehot(tap_sel))
        else $error("tap select not one-hot while enabled");
    a_tap_pos: assert property (@(posedge clk_sys) disable iff (rst)
        ladder_enable |-> tap_sel[level_code])
        else $error("tap position mismatches code");
    a_tap_off: assert property (@(posedge clk_sys) disable iff (rst)
        !ladder_enable |-> (tap_sel == 32'h0))
        else $error("taps closed while disabled");
    a_oe_follows: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && ctl0_wr) |=> (pin_drive_enable == $past(wr_data[ldac_pkg::LDAC_CTL0_OE_BIT])))
        else $error("pin drive did not follow write");
    a_pin_override: assert property (@(posedge clk_sys) disable iff (rst)
        pin_drive_enable |-> !(pin_oe || pin_in_en || pin_pullup_en || pin_ccd_en))
        else $error("digital pin function active during drive");
    a_pin_read_zero: assert property (@(posedge clk_sys) disable iff (rst)
        pin_drive_enable |-> (pin_rd == 1'b0))
        else $error("pin read not zero during drive");
    a_sleep_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (sleep_mode && !ctl0_wr && !ctl1_wr) |=> ($stable(ctl0_rd) && $stable(ctl1_rd)))
        else $error("control changed in sleep");
    a_wake_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (wake_event && !ctl0_wr) |=> $stable(ctl0_rd))
        else $error("control 0 changed on wake");
    a_reset_clear: assert property (@(posedge clk_sys)
        rst |=> (!ladder_enable && !pin_drive_enable && level_code == 5'h00))
        else $error("reset did not clear controls");
    a_pss_follows: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && ctl0_wr) |=>
        (positive_source_select == $past(wr_data[ldac_pkg::LDAC_CTL0_PSS_LSB +: 2])))
        else $error("positive select mismatch");
    a_nss_follows: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && ctl0_wr) |=> (negative_source_select == $past(wr_data[ldac_pkg::LDAC_CTL0_NSS_BIT])))
        else $error("negative select mismatch");

    // Level code write, separate from control 0 so both strobes may coincide
    a_code_follows: assert property (@(posedge clk_sys) disable iff (rst)
        (ce && ctl1_wr) |=> (level_code == $past(wr_data[ldac_pkg::LDAC_CODE_W-1:0])))
        else $error("level code did not follow write");
    // Unimplemented bits must read zero, or software masks would break
    a_rd0_unused: assert property (@(posedge clk_sys) disable iff (rst)
        (ctl0_rd & ~ldac_pkg::LDAC_CTL0_WMASK) == 8'h00)
        else $error("control 0 unused bits not zero");
    a_rd1_unused: assert property (@(posedge clk_sys) disable iff (rst)
        (ctl1_rd & ~ldac_pkg::LDAC_CTL1_WMASK) == 8'h00)
        else $error("control 1 unused bits not zero");
    // Port requests must reach the pin untouched when the level is not on it
    a_pin_pass: assert property (@(posedge clk_sys) disable iff (rst)
        !pin_drive_enable |-> (pin_oe == pin_dig_oe && pin_out == pin_dig_out && pin_in_en))
        else $error("digital pin function blocked without drive");
    // Clock enable low freezes the control words unless reset is high, which still clears them
    a_ce_freeze: assert property (@(posedge clk_sys) disable iff (rst)
        !ce |=> ($stable(ctl0_rd) && $stable(ctl1_rd)))
        else $error("control changed with clock enable low");
endmodule : ldac_ctrl
`default_nettype wire

// file: bench/ladder_dac_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ladder_dac_control_bench;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk_sys = 1'b0;   // 250 MHz system clock
    logic        rst     = 1'b1;   // Sync reset, held at start
    logic        ce      = 1'b1;   // Clock enable
    logic        sleep_mode = 1'b0, wake_event = 1'b0;
    logic        ctl0_wr = 1'b0, ctl1_wr = 1'b0;
    logic [7:0]  wr_data = 8'h00;  // Shared write byte
    logic        pin_in_raw = 1'b1;
    logic        pin_dig_out = 1'b1, pin_dig_oe = 1'b1, pin_pullup_req = 1'b1, pin_ccd_req = 1'b1;
    logic [7:0]  ctl0_rd, ctl1_rd;
    logic        pin_out, pin_oe, pin_in_en, pin_pullup_en, pin_ccd_en, pin_rd;
    logic        ladder_enable, pin_drive_enable, negative_source_select;
    logic [1:0]  positive_source_select;
    logic [4:0]  level_code;
    logic [31:0] tap_sel;
    int          miscompares = 0;  // Mismatch count
    int          n_compared  = 0;  // Comparison count
    // Row: two written bytes beside the readbacks they should give
    typedef struct { logic [7:0] w0, w1, e0, e1; } ldac_row_t;
    ldac_row_t   rows [6] = '{'{8'h80, 8'h00, 8'h80, 8'h00}, '{8'h85, 8'h1f, 8'h85, 8'h1f},
                              '{8'ha8, 8'h0a, 8'ha8, 8'h0a}, '{8'h2c, 8'h15, 8'h2c, 8'h15},
                              '{8'hff, 8'hff, 8'had, 8'h1f}, '{8'h52, 8'he0, 8'h00, 8'h00}};

    always #2 clk_sys = ~clk_sys;

    ldac_ctrl i_ldac_ctrl (.clk_sys(clk_sys), .rst(rst), .ce(ce), .sleep_mode(sleep_mode),
        .wake_event(wake_event), .ctl0_wr(ctl0_wr), .ctl1_wr(ctl1_wr), .wr_data(wr_data),
        .ctl0_rd(ctl0_rd), .ctl1_rd(ctl1_rd), .pin_in_raw(pin_in_raw), .pin_dig_out(pin_dig_out),
        .pin_dig_oe(pin_dig_oe), .pin_pullup_req(pin_pullup_req), .pin_ccd_req(pin_ccd_req),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_in_en(pin_in_en), .pin_pullup_en(pin_pullup_en),
        .pin_ccd_en(pin_ccd_en), .pin_rd(pin_rd), .ladder_enable(ladder_enable),
        .pin_drive_enable(pin_drive_enable), .positive_source_select(positive_source_select),
        .negative_source_select(negative_source_select), .level_code(level_code),
        .tap_sel(tap_sel));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic cmp(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : cmp

    // One-cycle strobe taken at the next rising edge
    task automatic wr(input logic s0, input logic s1, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        ctl0_wr = s0;
        ctl1_wr = s1;
        wr_data = d;
        @(posedge clk_sys);
        #1;
        ctl0_wr = 1'b0;
        ctl1_wr = 1'b0;
    endtask : wr

    // Every output against two expected control bytes; waits out the pin synchroniser
    task automatic chk(input logic [7:0] e0, input logic [7:0] e1);
        logic dr;
        dr = e0[5];
        repeat (2) @(posedge clk_sys);
        #1;
        cmp(ctl0_rd === e0 && ctl1_rd === e1, "readback");
        cmp(ladder_enable === e0[7], "enable");
        cmp(tap_sel === (e0[7] ? 32'h1 << e1[4:0] : 32'h0), "tap select");
        cmp(level_code === e1[4:0], "level code");
        cmp(positive_source_select === e0[3:2], "positive select");
        cmp(negative_source_select === e0[0], "negative select");
        cmp(pin_drive_enable === dr, "pin drive");
        cmp(pin_oe === (pin_dig_oe & ~dr) && pin_out === (pin_dig_out & ~dr), "buffer");
        cmp(pin_in_en === ~dr && pin_pullup_en === (pin_pullup_req & ~dr), "detector");
        cmp(pin_ccd_en === (pin_ccd_req & ~dr), "current drive");
        cmp(pin_rd === (dr ? 1'b0 : pin_in_raw), "pin read");
    endtask : chk

    task automatic finish_test;
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk(8'h00, 8'h00);
        foreach (rows[i]) begin
            wr(1'b1, 1'b0, rows[i].w0);
            wr(1'b0, 1'b1, rows[i].w1);
            chk(rows[i].e0, rows[i].e1);
        end
        // Both strobes in one cycle, masks applied per word
        wr(1'b1, 1'b1, 8'h9f);
        chk(8'h8d, 8'h1f);
        // Writes while the clock enable is low are dropped
        ce = 1'b0;
        wr(1'b1, 1'b1, 8'h00);
        ce = 1'b1;
        chk(8'h8d, 8'h1f);
        // Sleep with a wake pulse leaves everything standing
        sleep_mode = 1'b1;
        pin_in_raw = 1'b0;
        @(posedge clk_sys);
        #1;
        wake_event = 1'b1;
        @(posedge clk_sys);
        #1;
        wake_event = 1'b0;
        chk(8'h8d, 8'h1f);
        sleep_mode = 1'b0;
        chk(8'h8d, 8'h1f);
        // Driving state, then a second reset in mid-run
        wr(1'b1, 1'b0, 8'ha4);
        chk(8'ha4, 8'h1f);
        rst = 1'b1;
        @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk(8'h00, 8'h00);
        // Port requests low must pass straight through while not driving
        {pin_dig_out, pin_dig_oe, pin_pullup_req, pin_ccd_req} = 4'h0;
        pin_in_raw = 1'b1;
        wr(1'b1, 1'b1, 8'h81);
        chk(8'h81, 8'h01);
        // Reset with the clock enable low still clears the controls
        ce  = 1'b0;
        rst = 1'b1;
        @(posedge clk_sys);
        #1;
        rst = 1'b0;
        ce  = 1'b1;
        chk(8'h00, 8'h00);
        finish_test();
    end

    // Watchdog: whole sequence needs well under 2000 cycles
    initial begin
        #8000;
        miscompares++;
        finish_test();
    end
endmodule : ladder_dac_control_bench
`default_nettype wire
